//--- dv/slsa_rf_model.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_rf_model (
	input  wire logic        clk_i,
	input  wire logic        we_i,
	input  wire logic [4:0]  idx_i,
	input  wire logic [63:0] data_i
);
	// Records every write, index zero included, so a stray write shows.
	logic [63:0] regs [32] = '{default: 64'h0};
	always @(posedge clk_i) begin
		if (we_i) begin
			regs[idx_i] <= data_i;
		end
	end
endmodule : slsa_rf_model
`default_nettype wire

//--- dv/slsa_top_chk.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_top_chk (
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        ISSUE_VALID_I,
	input  wire logic [31:0] INSTR_I,
	input  wire logic [63:0] OPERAND_A_I,
	input  wire logic [63:0] OPERAND_B_I,
	input  wire logic        MODE64_I,
	input  wire logic        WB_VALID_O,
	input  wire logic [4:0]  WB_INDEX_O,
	input  wire logic [63:0] WB_DATA_O,
	input  wire logic        DONE_O,
	input  wire logic        UNKNOWN_O,
	input  wire logic        EXCEPTION_O
);
	wire logic        anz  = INSTR_I[25:21] != 5'h00;
	wire logic        rcls = ISSUE_VALID_I && INSTR_I[31:26] == 6'h00 && INSTR_I[20:16] != 5'h00;
	wire logic        sh_c = rcls && !anz && INSTR_I[5:0] == 6'h00;
	wire logic        sh_v = rcls && anz && INSTR_I[10:0] == 11'h004;
	wire logic [31:0] b_lo = OPERAND_B_I[31:0];
	wire logic [4:0]  amt  = INSTR_I[10:6];
	wire logic [4:0]  a5   = OPERAND_A_I[4:0];
	wire logic [4:0]  bidx = INSTR_I[20:16];
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);
	no_exception_a: assert property (!EXCEPTION_O) else $error("exception raised");
	idle_quiet_a: assert property (!ISSUE_VALID_I |=> !(DONE_O || UNKNOWN_O || WB_VALID_O))
		else $error("pulse without issue");
	one_answer_a: assert property (ISSUE_VALID_I |=> DONE_O != UNKNOWN_O)
		else $error("answer missing");
	zero_dest_a: assert property (WB_VALID_O |-> DONE_O && WB_INDEX_O != 5'h00)
		else $error("bad write");
	const_shift_a: assert property (sh_c |=> WB_DATA_O[31:0] == $past(b_lo) << $past(amt))
		else $error("const shift wrong");
	var_shift_a: assert property (sh_v |=> WB_DATA_O[31:0] == $past(b_lo) << $past(a5))
		else $error("var shift wrong");
	word_sext_a: assert property ((sh_c || sh_v) && MODE64_I
		|=> WB_DATA_O[63:32] == {32{WB_DATA_O[31]}}) else $error("no sign copy");
	imm_dest_a: assert property (ISSUE_VALID_I && INSTR_I[31:27] == 5'h05
		|=> WB_INDEX_O == $past(bidx) && WB_DATA_O[63:1] == 63'h0) else $error("imm compare");
	cover property (DONE_O && !WB_VALID_O);
	cover property (UNKNOWN_O);
	cover property (WB_VALID_O && WB_DATA_O[63]);
endmodule : slsa_top_chk
bind slsa_top slsa_top_chk u_chk (.CLK_I, .ARST_N_I, .ISSUE_VALID_I, .INSTR_I, .OPERAND_A_I,
	.OPERAND_B_I, .MODE64_I, .WB_VALID_O, .WB_INDEX_O, .WB_DATA_O, .DONE_O, .UNKNOWN_O,
	.EXCEPTION_O);
`default_nettype wire

//--- dv/slsa_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_top_tb_top;
	typedef struct packed {
		logic [31:0] ins;
		logic [63:0] a;
		logic [63:0] b;
		logic        m;
		logic [63:0] r;
	} slsa_row_type;
	logic CLK_I = 1'b0, ARST_N_I = 1'b0, ISSUE_VALID_I = 1'b0, MODE64_I = 1'b0;
	logic [31:0] INSTR_I = 32'h0;
	logic [63:0] OPERAND_A_I = 64'h0, OPERAND_B_I = 64'h0, WB_DATA_O;
	logic WB_VALID_O, DONE_O, UNKNOWN_O, EXCEPTION_O;
	logic [4:0] WB_INDEX_O;
	int miscompares = 0, checks = 0;
	slsa_row_type rows [9];
	always #2.5 CLK_I = ~CLK_I;
	slsa_top u_slsa_top (.CLK_I, .ARST_N_I, .ISSUE_VALID_I, .INSTR_I, .OPERAND_A_I, .OPERAND_B_I,
		.MODE64_I, .WB_VALID_O, .WB_INDEX_O, .WB_DATA_O, .DONE_O, .UNKNOWN_O, .EXCEPTION_O);
	slsa_rf_model u_slsa_rf_model (.clk_i(CLK_I), .we_i(WB_VALID_O), .idx_i(WB_INDEX_O),
		.data_i(WB_DATA_O));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	// Valid stays high between calls, so calls in a row issue back to back.
	task op(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b, input logic m);
		ISSUE_VALID_I = 1'b1;
		INSTR_I = ins;
		OPERAND_A_I = a;
		OPERAND_B_I = b;
		MODE64_I = m;
		@(posedge CLK_I);
		#1;
	endtask : op
	initial begin
		#2000;
		miscompares++;
		give_verdict();
	end
	initial begin
		rows[0] = '{32'h00021900, 64'h0, 64'h8000001, 1'b1, 64'hffffffff80000010};
		rows[1] = '{32'h00021800, 64'h0, 64'h123456789abcdef0, 1'b1, 64'hffffffff9abcdef0};
		rows[2] = '{32'h00021fc0, 64'h0, 64'h3, 1'b0, 64'h80000000};
		rows[3] = '{32'h00222004, 64'hffffffe4, 64'hfff000008000001, 1'b1, 64'hffffffff80000010};
		rows[4] = '{32'h0022282a, 64'h8000000000000000, 64'h1, 1'b1, 64'h1};
		rows[5] = '{32'h0022282b, 64'h8000000000000000, 64'h1, 1'b1, 64'h0};
		rows[6] = '{32'h2826ffff, 64'hfffffffffffffffe, 64'h0, 1'b1, 64'h1};
		rows[7] = '{32'h2c268000, 64'h10000, 64'h0, 1'b1, 64'h1};
		rows[8] = '{32'h0022282a, 64'hffffffff00000001, 64'h80000000, 1'b0, 64'h0};
		repeat (8) @(posedge CLK_I);
		#1;
		chk({WB_VALID_O, DONE_O, UNKNOWN_O, EXCEPTION_O}, 64'h0);
		ARST_N_I = 1'b1;
		foreach (rows[i]) begin
			op(rows[i].ins, rows[i].a, rows[i].b, rows[i].m);
			chk(WB_DATA_O, rows[i].r);
			chk(WB_INDEX_O, rows[i].ins[31:26] != 0 ? rows[i].ins[20:16] : rows[i].ins[15:11]);
			chk({DONE_O, WB_VALID_O, UNKNOWN_O, EXCEPTION_O}, 64'hc);
		end
		op(32'h00222044, 64'h1, 64'h1, 1'b1);
		chk({UNKNOWN_O, DONE_O, WB_VALID_O}, 64'h4);
		op(32'h00421900, 64'h1, 64'h1, 1'b1);
		chk({UNKNOWN_O, DONE_O, WB_VALID_O}, 64'h4);
		op(32'h0022002a, 64'h0, 64'h5, 1'b1);
		chk({UNKNOWN_O, DONE_O, WB_VALID_O}, 64'h2);
		ISSUE_VALID_I = 1'b0;
		@(posedge CLK_I);
		#1;
		chk({UNKNOWN_O, DONE_O, WB_VALID_O}, 64'h0);
		chk(u_slsa_rf_model.regs[0], 64'h0);
		chk(u_slsa_rf_model.regs[3], 64'h80000000);
		chk(u_slsa_rf_model.regs[6], 64'h1);
		ARST_N_I = 1'b0;
		#1;
		chk(WB_DATA_O, 64'h0);
		chk({WB_VALID_O, DONE_O, UNKNOWN_O, WB_INDEX_O}, 64'h0);
		@(posedge CLK_I);
		#1;
		ARST_N_I = 1'b1;
		op(rows[0].ins, rows[0].a, rows[0].b, rows[0].m);
		chk(WB_DATA_O, rows[0].r);
		chk({DONE_O, WB_VALID_O}, 64'h3);
		give_verdict();
	end
endmodule : slsa_top_tb_top
`default_nettype wire

//--- logic/slsa_compare.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_compare (
	input  wire logic [63:0] a_i,
	input  wire logic [63:0] b_i,
	input  wire logic        unsigned_i,
	input  wire logic        mode64_i,
	output logic             less_o
);

	// Direct magnitude compare; no subtraction, so no overflow can corrupt it.
	always_comb begin
		if (mode64_i) begin
			if (unsigned_i) begin
				less_o = (a_i < b_i);
			end else begin
				less_o = ($signed(a_i) < $signed(b_i));
			end
		end else begin
			if (unsigned_i) begin
				less_o = (a_i[31:0] < b_i[31:0]);
			end else begin
				less_o = ($signed(a_i[31:0]) < $signed(b_i[31:0]));
			end
		end
	end

endmodule : slsa_compare
`default_nettype wire

//--- logic/slsa_pkg.sv
// Functional notes
// - Constant left shift: class 0, function 0, bits 25..21 zero, amount bits 10..6.
// - Register class functions 000100, 101010, 101011 with bits 10..6 zero.
// - Opcodes 001010 and 001011 compare against a 16-bit immediate, signed and unsigned.
// - Constant shift moves operand B left, zero fill, writes destination.
// - In 64-bit mode the constant shift result is sign-extended from bit 31.
// - Constant shift applies no operand check; any source gives a valid word.
// - Variable shift count is the low five bits of operand A.
// - In 64-bit mode the variable shift result is sign-extended for every count.
// - Variable shift result is valid whatever the upper source bits hold.
// - Signed register compare writes one when A is less than B.
// - Unsigned register compare writes one when A is less than B.
// - Signed immediate compare sign-extends immediate, writes the operand B index.
// - Unsigned immediate compare sign-extends immediate then compares unsigned.
// - Compares never raise overflow and stay correct when subtraction overflows.
package slsa_pkg;

	localparam int XLEN    = 64;
	localparam int WLEN    = 32;
	localparam int IMM_W   = 16;
	localparam int IDX_W   = 5;
	localparam int OPC_MSB = 31;
	localparam int OPC_LSB = 26;
	localparam int IA_MSB  = 25;
	localparam int IA_LSB  = 21;
	localparam int IB_MSB  = 20;
	localparam int IB_LSB  = 16;
	localparam int RD_MSB  = 15;
	localparam int RD_LSB  = 11;
	localparam int AMT_MSB = 10;
	localparam int AMT_LSB = 6;
	localparam int FN_MSB  = 5;
	localparam int FN_LSB  = 0;
	localparam int IMM_MSB = 15;

	localparam logic [5:0]  OPC_REG_CLASS = 6'h00;
	localparam logic [5:0]  OPC_LTI_S     = 6'h0a;
	localparam logic [5:0]  OPC_LTI_U     = 6'h0b;
	localparam logic [5:0]  FN_SHL_CONST  = 6'h00;
	localparam logic [5:0]  FN_SHL_VAR    = 6'h04;
	localparam logic [5:0]  FN_LT_S       = 6'h2a;
	localparam logic [5:0]  FN_LT_U       = 6'h2b;
	localparam logic [4:0]  ZERO_IDX      = 5'h00;
	localparam logic [63:0] RESULT_RST    = 64'h0;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SHL_CONST,
		OP_SHL_VAR,
		OP_LT_S,
		OP_LT_U,
		OP_LTI_S,
		OP_LTI_U
	} slsa_op_type;

	// Widens a word: sign copy in 64-bit mode, zero upper word in 32-bit mode.
	function automatic logic [63:0] widen_word(input logic [31:0] w, input logic mode64);
		widen_word = mode64 ? {{WLEN{w[WLEN-1]}}, w} : {32'h0, w};
	endfunction : widen_word

	// Sign-extends a 16-bit immediate to full width.
	function automatic logic [63:0] sext_imm(input logic [15:0] imm);
		sext_imm = {{(XLEN-IMM_W){imm[IMM_MSB]}}, imm};
	endfunction : sext_imm

	// Maps an instruction word to one of the six operations, or to OP_NONE when none matches.
	function automatic slsa_op_type decode_op(input logic [31:0] ins);
		logic [5:0] opc;
		logic [5:0] fn;
		logic       a_idx_zero;
		logic       amt_zero;
		opc        = ins[OPC_MSB:OPC_LSB];
		fn         = ins[FN_MSB:FN_LSB];
		a_idx_zero = (ins[IA_MSB:IA_LSB] == ZERO_IDX);
		amt_zero   = (ins[AMT_MSB:AMT_LSB] == ZERO_IDX);
		decode_op  = OP_NONE;
		if (opc == OPC_REG_CLASS) begin
			if (fn == FN_SHL_CONST && a_idx_zero) begin
				decode_op = OP_SHL_CONST;
			end else if (fn == FN_SHL_VAR && amt_zero) begin
				decode_op = OP_SHL_VAR;
			end else if (fn == FN_LT_S && amt_zero) begin
				decode_op = OP_LT_S;
			end else if (fn == FN_LT_U && amt_zero) begin
				decode_op = OP_LT_U;
			end
		end else if (opc == OPC_LTI_S) begin
			decode_op = OP_LTI_S;
		end else if (opc == OPC_LTI_U) begin
			decode_op = OP_LTI_U;
		end
	endfunction : decode_op

endpackage : slsa_pkg

//--- logic/slsa_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_shifter (
	input  wire logic [63:0] operand_i,
	input  wire logic [4:0]  amount_i,
	input  wire logic        mode64_i,
	output logic      [63:0] result_o
);

	logic [31:0] word;

	// Only the low word enters; upper source bits are ignored, so no operand check exists.
	always_comb begin
		word     = operand_i[31:0] << amount_i;
		result_o = slsa_pkg::widen_word(word, mode64_i);
	end

endmodule : slsa_shifter
`default_nettype wire

//--- logic/slsa_top.sv
`timescale 1ns/10ps
`default_nettype none
module slsa_top (
	input  wire logic        CLK_I,
	input  wire logic        ARST_N_I,
	input  wire logic        ISSUE_VALID_I,
	input  wire logic [31:0] INSTR_I,
	input  wire logic [63:0] OPERAND_A_I,
	input  wire logic [63:0] OPERAND_B_I,
	input  wire logic        MODE64_I,
	output logic             WB_VALID_O,
	output logic      [4:0]  WB_INDEX_O,
	output logic      [63:0] WB_DATA_O,
	output logic             DONE_O,
	output logic             UNKNOWN_O,
	output logic             EXCEPTION_O
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic        wb_valid;
		logic [4:0]  wb_index;
		logic [63:0] wb_data;
		logic        done;
		logic        unknown;
		logic        exception;
	} slsa_state_type;

	slsa_state_type      state;
	slsa_state_type      next_state;
	slsa_pkg::slsa_op_type op;
	logic [4:0]          idx_a;
	logic [4:0]          idx_b;
	logic [4:0]          idx_d;
	logic [4:0]          shift_amount;
	logic [63:0]         opnd_a;
	logic [63:0]         opnd_b;
	logic [63:0]         cmp_b;
	logic [63:0]         shift_result;
	logic                cmp_unsigned;
	logic                is_shift;
	logic                is_imm;
	logic                less;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and operand selection.

	always_comb begin
		op     = slsa_pkg::decode_op(INSTR_I);
		idx_a  = INSTR_I[slsa_pkg::IA_MSB:slsa_pkg::IA_LSB];
		idx_b  = INSTR_I[slsa_pkg::IB_MSB:slsa_pkg::IB_LSB];
		is_imm = (op == slsa_pkg::OP_LTI_S) || (op == slsa_pkg::OP_LTI_U);
		is_shift = (op == slsa_pkg::OP_SHL_CONST) || (op == slsa_pkg::OP_SHL_VAR);
		// Register zero always reads as zero, whatever the file presents.
		opnd_a = (idx_a == slsa_pkg::ZERO_IDX) ? slsa_pkg::RESULT_RST : OPERAND_A_I;
		opnd_b = (idx_b == slsa_pkg::ZERO_IDX) ? slsa_pkg::RESULT_RST : OPERAND_B_I;
		if (is_imm) begin
			idx_d = idx_b;
			cmp_b = slsa_pkg::sext_imm(INSTR_I[slsa_pkg::IMM_MSB:0]);
		end else begin
			idx_d = INSTR_I[slsa_pkg::RD_MSB:slsa_pkg::RD_LSB];
			cmp_b = opnd_b;
		end
		if (op == slsa_pkg::OP_SHL_CONST) begin
			shift_amount = INSTR_I[slsa_pkg::AMT_MSB:slsa_pkg::AMT_LSB];
		end else begin
			shift_amount = opnd_a[4:0];
		end
		cmp_unsigned = (op == slsa_pkg::OP_LT_U) || (op == slsa_pkg::OP_LTI_U);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Datapath.

	slsa_shifter u_shifter (
		.operand_i (opnd_b),
		.amount_i  (shift_amount),
		.mode64_i  (MODE64_I),
		.result_o  (shift_result)
	);

	slsa_compare u_compare (
		.a_i        (opnd_a),
		.b_i        (cmp_b),
		.unsigned_i (cmp_unsigned),
		.mode64_i   (MODE64_I),
		.less_o     (less)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state; one issue gives at most one write-back, on the following edge.

	always_comb begin
		next_state           = state;
		next_state.wb_valid  = 1'b0;
		next_state.done      = 1'b0;
		next_state.unknown   = 1'b0;
		next_state.exception = 1'b0;
		if (ISSUE_VALID_I) begin
			if (op == slsa_pkg::OP_NONE) begin
				next_state.unknown = 1'b1;
			end else begin
				next_state.done     = 1'b1;
				next_state.wb_valid = (idx_d != slsa_pkg::ZERO_IDX);
				next_state.wb_index = idx_d;
				if (is_shift) begin
					next_state.wb_data = shift_result;
				end else begin
					next_state.wb_data = {63'h0, less};
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	always_comb begin
		WB_VALID_O  = state.wb_valid;
		WB_INDEX_O  = state.wb_index;
		WB_DATA_O   = state.wb_data;
		DONE_O      = state.done;
		UNKNOWN_O   = state.unknown;
		EXCEPTION_O = state.exception;
	end

endmodule : slsa_top
`default_nettype wire
